// ===== logic/ccp_command_enable.sv
// command pointer and enable register of a colour sensor serial interface
// assumes a serial front end on linkClk gives one strobe per byte;
// byte strobes must be spaced by at least four system clocks
`timescale 1ns/1ps
module ccp_command_enable
   import ccp_pkg::*;
#(
   parameter int WARMUP_CNT = ccp_pkg::WARMUP_CYCLES
) (
   input  wire logic       clk,
   input  wire logic       sys_rst,
   input  wire logic       linkClk,
   input  wire logic       linkCmdStb,
   input  wire logic       linkWrStb,
   input  wire logic       linkRdStb,
   input  wire logic [7:0] linkByte,
   input  wire logic       colorIrqEvent,
   output logic [7:0]      rdData,
   output logic [4:0]      regPointer,
   output logic            autoIncrement,
   output logic            regWrStb,
   output logic [7:0]      regWrData,
   output logic            oscillatorRun,
   output logic            colorAdcRun,
   output logic            waitTimerRun,
   output logic            conversionAllowed,
   output logic            colorIrq
);
   import ccp_pkg::*;

   ccp_link_if lnk ();

   ccp_link_capture u_capture (
      .linkClk    (linkClk),
      .sys_rst    (sys_rst),
      .linkCmdStb (linkCmdStb),
      .linkWrStb  (linkWrStb),
      .linkRdStb  (linkRdStb),
      .linkByte   (linkByte),
      .lnk        (lnk)
   );

   // toggle synchronisers: three stages, an event when stages two and
   // three differ, so stage one feeds nothing but stage two
   localparam int EV_COUNT = 3;
   logic [EV_COUNT-1:0] tglIn;
   logic [EV_COUNT-1:0] evOut;
   logic                cmdEv;
   logic                wrEv;
   logic                rdEv;

   assign tglIn = {lnk.rdTgl, lnk.wrTgl, lnk.cmdTgl};

   for (genvar g = 0; g < EV_COUNT; g++) begin : g_sync
      logic [2:0] sync_r;
      always_ff @(posedge clk or posedge sys_rst) begin
         if (sys_rst) begin
            sync_r <= 3'h0;
         end else begin
            sync_r <= {sync_r[1:0], tglIn[g]};
         end
      end
      // a toggle, not a pulse, so a strobe shorter than clk is not lost
      assign evOut[g] = sync_r[2] ^ sync_r[1];
   end

   assign cmdEv = evOut[0];
   assign wrEv  = evOut[1];
   assign rdEv  = evOut[2];

   // wrByte changes on the same link clock edge as its toggle, so it has settled by the time the toggle clears the synchroniser
   logic [7:0] cmdByte;
   logic [1:0] kind;
   logic       isCommand;
   assign cmdByte   = lnk.wrByte;
   assign isCommand = cmdEv && cmdByte[CMD_BIT];
   assign kind      = cmdByte[KIND_HI:KIND_LO];

   function automatic logic hits_enables(input logic [4:0] p);
      return p == ENABLES_ADDR;
   endfunction : hits_enables

   // pointer and mode
   // the pointer wraps from the top register back to zero in auto mode
   logic [4:0] pointer_r;
   logic       autoInc_r;
   logic       irqClear;

   assign irqClear = isCommand && (kind == KIND_SPECIAL)
                     && (cmdByte[ADDR_W-1:0] == SF_IRQ_CLEAR);

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pointer_r <= 5'h00;
         autoInc_r <= 1'b0;
      end else if (isCommand && kind != KIND_SPECIAL
                   && kind != KIND_RSVD) begin
         pointer_r <= cmdByte[ADDR_W-1:0];
         autoInc_r <= (kind == KIND_AUTOINC);
      end else if ((rdEv || wrEv) && autoInc_r) begin
         pointer_r <= pointer_r + 5'h01;
      end
      // special and reserved kinds fall through untouched
      // repeated-byte access keeps the pointer
   end

   // enable register
   // the oscillator bit gates everything downstream, see the assigns below
   logic [7:0] enables_r;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         enables_r <= ENABLES_RESET;
      end else if (wrEv && hits_enables(pointer_r)) begin
         // reserved bits forced to zero so they cannot steer anything
         enables_r <= cmdByte & ENABLES_WMASK;
      end
   end

   // register write strobe to the rest of the register bank
   // reads never pulse the strobe; only data writes reach the bank
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         regWrStb  <= 1'b0;
         regWrData <= 8'h00;
      end else begin
         regWrStb  <= wrEv;
         regWrData <= wrEv ? cmdByte : regWrData;
      end
   end

   // readback: only the enables live in this block; any other pointer
   // reads zero here and the rest of the bank supplies its own data
   logic [7:0] rdData_nxt;
   always_comb begin
      rdData_nxt = 8'h00;
      if (hits_enables(pointer_r)) begin
         rdData_nxt = enables_r;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rdData <= 8'h00;
      end else begin
         rdData <= rdData_nxt;
      end
   end

   // power-up sequencer
   // losing power mid warm-up goes back to sleep and restarts the delay
   ccp_state_type state_r;
   logic [$clog2(WARMUP_CNT+1)-1:0] warm_r;
   logic powerOn;
   assign powerOn = enables_r[EN_POWER];

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_r <= ST_SLEEP;
         warm_r  <= '0;
      end else begin
         case (state_r)
            ST_SLEEP: begin
               warm_r <= '0;
               if (powerOn) begin
                  state_r <= ST_WARMUP;
               end
            end
            ST_WARMUP: begin
               if (!powerOn) begin
                  state_r <= ST_SLEEP;
               end else if (warm_r == WARMUP_CNT - 1) begin
                  state_r <= ST_READY;
               end else begin
                  warm_r <= warm_r + 1'b1;
               end
            end
            ST_READY: begin
               if (!powerOn) begin
                  state_r <= ST_SLEEP;
               end
            end
            default: state_r <= ST_SLEEP;
         endcase
      end
   end

   // interrupt: set wins over clear in the same cycle
   // clearing the allow bit also drops a request already pending
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         colorIrq <= 1'b0;
      end else if (!enables_r[EN_IRQ]) begin
         colorIrq <= 1'b0;
      end else if (colorIrqEvent && conversionAllowed) begin
         colorIrq <= 1'b1;
      end else if (irqClear) begin
         colorIrq <= 1'b0;
      end
   end

   assign oscillatorRun     = powerOn;
   assign colorAdcRun       = powerOn && enables_r[EN_ADC];
   assign waitTimerRun      = powerOn && enables_r[EN_WAIT];
   assign conversionAllowed = colorAdcRun && (state_r == ST_READY);
   assign regPointer        = pointer_r;
   assign autoIncrement     = autoInc_r;
endmodule : ccp_command_enable

// ===== logic/ccp_pkg.sv
// package for the command pointer and enable control block
// assumes a byte-wide register access path from a serial slave front end
package ccp_pkg;
   localparam int  ADDR_W         = 5;
   localparam int  CMD_BIT        = 7;
   localparam int  KIND_HI        = 6;
   localparam int  KIND_LO        = 5;
   localparam logic [1:0] KIND_REPEAT = 2'h0;
   localparam logic [1:0] KIND_AUTOINC = 2'h1;
   localparam logic [1:0] KIND_RSVD   = 2'h2;
   localparam logic [1:0] KIND_SPECIAL = 2'h3;
   localparam logic [4:0] SF_IRQ_CLEAR = 5'h06;
   localparam logic [4:0] ENABLES_ADDR = 5'h00;
   localparam logic [7:0] ENABLES_RESET = 8'h00;
   localparam logic [7:0] ENABLES_WMASK = 8'h1b;
   localparam int  EN_POWER       = 0;
   localparam int  EN_ADC         = 1;
   localparam int  EN_WAIT        = 3;
   localparam int  EN_IRQ         = 4;
   localparam real CLK_MHZ        = 100.0;
   localparam real WARMUP_US      = 2400.0;
   localparam int  WARMUP_CYCLES  = int'($ceil(WARMUP_US * CLK_MHZ));
   typedef enum {ST_SLEEP, ST_WARMUP, ST_READY} ccp_state_type;
endpackage : ccp_pkg

// ===== logic/ccp_link_if.sv
// link-side byte events handed from the serial front end domain
// assumes events are toggles, crossed into the system clock domain
`timescale 1ns/1ps
interface ccp_link_if;
   logic       cmdTgl;
   logic       wrTgl;
   logic       rdTgl;
   logic [7:0] wrByte;
   modport src (output cmdTgl, output wrTgl, output rdTgl, output wrByte);
   modport dst (input cmdTgl, input wrTgl, input rdTgl, input wrByte);
endinterface : ccp_link_if

// ===== logic/ccp_link_capture.sv
// link clock side: turns byte strobes into toggles plus a held data word
// assumes linkClk may stop between frames; toggles keep last state
`timescale 1ns/1ps
module ccp_link_capture (
   input  wire logic linkClk,
   input  wire logic sys_rst,
   input  wire logic linkCmdStb,
   input  wire logic linkWrStb,
   input  wire logic linkRdStb,
   input  wire logic [7:0] linkByte,
   ccp_link_if.src   lnk
);
   always_ff @(posedge linkClk or posedge sys_rst) begin
      if (sys_rst) begin
         lnk.cmdTgl <= 1'b0;
         lnk.wrTgl  <= 1'b0;
         lnk.rdTgl  <= 1'b0;
         lnk.wrByte <= 8'h00;
      end else begin
         // data held until the next command or write strobe, so it is stable when read
         if (linkCmdStb || linkWrStb) begin
            lnk.wrByte <= linkByte;
         end
         if (linkCmdStb) begin
            lnk.cmdTgl <= ~lnk.cmdTgl;
         end
         if (linkWrStb) begin
            lnk.wrTgl <= ~lnk.wrTgl;
         end
         if (linkRdStb) begin
            lnk.rdTgl <= ~lnk.rdTgl;
         end
      end
   end
endmodule : ccp_link_capture

// ===== dv/ccp_chk.sv
// timing checks on the command pointer and enable outputs
// assumes binding to ccp_command_enable, all in the clk domain
`timescale 1ns/1ps
module ccp_chk (
   input wire logic       clk,
   input wire logic       sys_rst,
   input wire logic [7:0] rdData,
   input wire logic [4:0] regPointer,
   input wire logic       oscillatorRun,
   input wire logic       colorAdcRun,
   input wire logic       waitTimerRun,
   input wire logic       conversionAllowed,
   input wire logic       colorIrq
);
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   adc_gate_a: assert property (($past(regPointer) == 5'h00) |->
      $past(colorAdcRun) == (rdData[1] && rdData[0]))
      else $error("adc run disagrees with enables readback");
   wait_gate_a: assert property (($past(regPointer) == 5'h00) |->
      $past(waitTimerRun) == (rdData[3] && rdData[0]))
      else $error("wait timer disagrees with enables readback");
   conv_gate_a: assert property (conversionAllowed |->
      colorAdcRun && $past(oscillatorRun, 8))
      else $error("conversion allowed too early or with adc off");
   warm_hold_a: assert property ($rose(oscillatorRun) |->
      !conversionAllowed [*8]) else $error("warm-up cut short");
   rd_map_a: assert property (($past(regPointer) != 5'h00) &&
      $stable(regPointer) |-> rdData == 8'h00)
      else $error("unmapped pointer reads nonzero");
   rd_enab_a: assert property (($past(regPointer) == 5'h00) &&
      $stable(regPointer) |-> rdData[0] == $past(oscillatorRun))
      else $error("enables readback disagrees with oscillator");
   irq_gate_a: assert property ($rose(colorIrq) |->
      $past(conversionAllowed)) else $error("interrupt while not allowed");
   ptr_step_a: assert property ($changed(regPointer) |=>
      $stable(regPointer) [*2]) else $error("pointer stepped too fast");
endmodule : ccp_chk

bind ccp_command_enable ccp_chk u_chk (.clk(clk), .sys_rst(sys_rst),
   .rdData(rdData), .regPointer(regPointer),
   .oscillatorRun(oscillatorRun), .colorAdcRun(colorAdcRun),
   .waitTimerRun(waitTimerRun), .conversionAllowed(conversionAllowed),
   .colorIrq(colorIrq));

// ===== dv/ccp_host_model.sv
// serial host model: one strobed byte per call on a gated link clock
// assumes the caller spaces calls by at least four system clocks
`timescale 1ns/1ps
module ccp_host_model (
   output logic       linkClk,
   output logic       linkCmdStb,
   output logic       linkWrStb,
   output logic       linkRdStb,
   output logic [7:0] linkByte
);
   initial begin
      {linkClk, linkCmdStb, linkWrStb, linkRdStb} = 4'h0;
      linkByte = 8'h5a;
   end
   // clock only runs inside a transfer, like a real stopped bus
   task automatic pulse(input int n);
      repeat (n) begin
         #3 linkClk = 1'b1;
         #3 linkClk = 1'b0;
      end
   endtask : pulse
   task automatic put(input logic [2:0] kind, input logic [7:0] b);
      {linkCmdStb, linkWrStb, linkRdStb} = kind;
      linkByte = b;
      pulse(1);
      {linkCmdStb, linkWrStb, linkRdStb} = 3'h0;
      // released data is not left looking valid
      linkByte = ~b;
      pulse(2);
   endtask : put
endmodule : ccp_host_model

// ===== dv/testbench.sv
// self-checking bench for the command pointer and enable block
// assumes the host model drives the link pins on its own clock
`timescale 1ns/1ps
module testbench;
   localparam logic [2:0] CMD = 3'h4, WR = 3'h2, RD = 3'h1;
   logic            clk, sys_rst, colorIrqEvent;
   wire logic       linkClk, linkCmdStb, linkWrStb, linkRdStb;
   wire logic [7:0] linkByte, rdData, regWrData;
   wire logic [4:0] regPointer;
   wire logic       autoIncrement, regWrStb, oscillatorRun, colorAdcRun;
   wire logic       waitTimerRun, conversionAllowed, colorIrq;
   int              errors, checks;
   int              wrSeen = 0;
   logic [10:0]     enTab [7] = '{11'h00a, 11'h002, 11'h008, 11'h000,
                                  11'h519, 11'h313, 11'h71b};
   logic [7:0]      badCmd [3] = '{8'hc3, 8'he5, 8'h07};
   always #5 clk = ~clk;
   always @(negedge clk) if (regWrStb === 1'b1) wrSeen++;
   ccp_host_model host (.linkClk(linkClk), .linkCmdStb(linkCmdStb),
      .linkWrStb(linkWrStb), .linkRdStb(linkRdStb), .linkByte(linkByte));
   ccp_command_enable #(.WARMUP_CNT(20)) dut (.clk(clk), .sys_rst(sys_rst),
      .linkClk(linkClk), .linkCmdStb(linkCmdStb), .linkWrStb(linkWrStb),
      .linkRdStb(linkRdStb), .linkByte(linkByte), .rdData(rdData),
      .colorIrqEvent(colorIrqEvent), .regPointer(regPointer),
      .autoIncrement(autoIncrement), .regWrStb(regWrStb),
      .regWrData(regWrData), .oscillatorRun(oscillatorRun),
      .colorAdcRun(colorAdcRun), .waitTimerRun(waitTimerRun),
      .conversionAllowed(conversionAllowed), .colorIrq(colorIrq));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic op(input logic [2:0] kind, input logic [7:0] b);
      host.put(kind, b);
      repeat (10) @(posedge clk);
      @(negedge clk);
   endtask : op
   task automatic irq_pulse;
      @(negedge clk) colorIrqEvent = 1'b1;
      @(negedge clk) colorIrqEvent = 1'b0;
      repeat (6) @(negedge clk);
   endtask : irq_pulse
   task automatic report_and_stop;
      $display("checks=%0d errors=%0d", checks, errors);
      if (errors == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : report_and_stop
   initial begin
      #100us;
      errors++;
      report_and_stop;
   end
   initial begin
      clk = 1'b0;
      sys_rst = 1'b1;
      colorIrqEvent = 1'b0;
      errors = 0;
      checks = 0;
      host.pulse(2);
      repeat (20) @(posedge clk);
      @(negedge clk) sys_rst = 1'b0;
      chk(oscillatorRun, 1'b0);
      op(CMD, 8'h80);
      chk(rdData, 8'h00);
      chk(autoIncrement, 1'b0);
      foreach (enTab[i]) begin
         op(WR, enTab[i][7:0]);
         chk({waitTimerRun, colorAdcRun, oscillatorRun}, enTab[i][10:8]);
      end
      chk(rdData, 8'h1b);
      repeat (30) @(negedge clk);
      chk(conversionAllowed, 1'b1);
      $display("test enables done");
      irq_pulse;
      chk(colorIrq, 1'b1);
      op(CMD, 8'he6);
      chk(colorIrq, 1'b0);
      chk(regPointer, 5'h00);
      op(WR, 8'h0b);
      chk(regWrData, 8'h0b);
      irq_pulse;
      chk(colorIrq, 1'b0);
      $display("test interrupt done");
      op(CMD, 8'ha5);
      foreach (badCmd[i]) begin
         op(CMD, badCmd[i]);
         chk({autoIncrement, regPointer}, 6'h25);
      end
      $display("test refused done");
      op(CMD, 8'hbe);
      op(RD, 8'h00);
      chk(regPointer, 5'h1f);
      op(RD, 8'h00);
      chk(regPointer, 5'h00);
      chk(rdData, 8'h0b);
      op(CMD, 8'h83);
      op(RD, 8'h00);
      chk(regPointer, 5'h03);
      $display("test pointer done");
      @(negedge clk) sys_rst = 1'b1;
      host.pulse(2);
      repeat (3) @(negedge clk);
      sys_rst = 1'b0;
      chk({oscillatorRun, autoIncrement, regPointer}, 8'h00);
      chk(regWrData, 8'h00);
      op(WR, 8'h03);
      chk(conversionAllowed, 1'b0);
      chk(rdData, 8'h03);
      chk(regWrData, 8'h03);
      repeat (20) @(negedge clk);
      chk(conversionAllowed, 1'b1);
      chk(wrSeen[7:0], 8'h09);
      $display("test reset done");
      report_and_stop;
   end
endmodule : testbench
